// ==== design/cmbd_decoder.sv ====
// Opcode decode and sequencing for data moves, branches and bit operations.
// Assumes a code memory that answers each held read with a code_valid beat,
// and a datapath that supplies flags and carries out the reported operation.
`timescale 1ns/100ps
`default_nettype none

module cmbd_decoder (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 reset,
	// program memory
	output logic                      code_rd,
	output logic [15:0]               program_counter,
	input  wire logic [7:0]           code_data,
	input  wire logic                 code_valid,
	// datapath status
	input  wire logic [7:0]           acc,
	input  wire logic [15:0]          data_pointer,
	input  wire logic                 acc_is_zero,
	input  wire logic                 carry_flag,
	input  wire logic                 bit_value,
	input  wire logic                 compare_unequal,
	input  wire logic                 decrement_nonzero,
	input  wire logic [7:0]           power_control,
	// operand seen so far
	output logic [7:0]                operand1,
	// execute report
	output logic                      exec_valid,
	output var cmbd_pkg::cmbd_class_t exec_class,
	output logic [7:0]                exec_opcode,
	output logic [7:0]                exec_op1,
	output logic [7:0]                exec_op2,
	output logic                      exec_taken,
	output logic                      exec_bit_clear,
	output logic                      exec_xmem_alt
);

	// ==========================================================
	// opcode table: class, length, cycles
	function automatic logic [10:0] decode(input logic [7:0] op);
		cmbd_pkg::cmbd_class_t c;
		logic [1:0]            l;
		logic [2:0]            y;
		c = cmbd_pkg::CL_OTHER;
		l = cmbd_pkg::LEN1;
		y = cmbd_pkg::CYC1;
		case (op) inside
			[cmbd_pkg::OP_MOV_A_REG_LO:cmbd_pkg::OP_MOV_A_REG_HI]: begin
				c = cmbd_pkg::CL_MOV_A_REG; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC1;
			end
			cmbd_pkg::OP_MOV_A_DIR: begin
				c = cmbd_pkg::CL_MOV_A_DIR; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_MOV_A_IMM: begin
				c = cmbd_pkg::CL_MOV_A_IMM; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			[cmbd_pkg::OP_MOV_REG_A_LO:cmbd_pkg::OP_MOV_REG_A_HI]: begin
				c = cmbd_pkg::CL_MOV_REG_A; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC2;
			end
			[cmbd_pkg::OP_MOV_REG_DIR_LO:cmbd_pkg::OP_MOV_REG_DIR_HI]: begin
				c = cmbd_pkg::CL_MOV_REG_DIR; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_MOV_DIR_DIR: begin
				c = cmbd_pkg::CL_MOV_DIR_DIR; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_LOAD_DP: begin
				c = cmbd_pkg::CL_LOAD_DP; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_CODE_LOAD_DP: begin
				c = cmbd_pkg::CL_CODE_LOAD_DP; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_CODE_LOAD_PC: begin
				c = cmbd_pkg::CL_CODE_LOAD_PC; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC3;
			end
			[cmbd_pkg::OP_XRD_IND_LO:cmbd_pkg::OP_XRD_IND_HI]: begin
				c = cmbd_pkg::CL_XRD_IND; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_XRD_DP: begin
				c = cmbd_pkg::CL_XRD_DP; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC4;
			end
			[cmbd_pkg::OP_XWR_IND_LO:cmbd_pkg::OP_XWR_IND_HI]: begin
				c = cmbd_pkg::CL_XWR_IND; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC5;
			end
			cmbd_pkg::OP_XWR_DP: begin
				c = cmbd_pkg::CL_XWR_DP; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC5;
			end
			cmbd_pkg::OP_PUSH: begin
				c = cmbd_pkg::CL_PUSH; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_POP: begin
				c = cmbd_pkg::CL_POP; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			[cmbd_pkg::OP_XCH_REG_LO:cmbd_pkg::OP_XCH_REG_HI]: begin
				c = cmbd_pkg::CL_XCH_REG; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC2;
			end
			[cmbd_pkg::OP_XCH_IND_LO:cmbd_pkg::OP_XCH_IND_HI]: begin
				c = cmbd_pkg::CL_XCH_IND; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_XCH_DIR: begin
				c = cmbd_pkg::CL_XCH_DIR; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			[cmbd_pkg::OP_NIB_XCH_LO:cmbd_pkg::OP_NIB_XCH_HI]: begin
				c = cmbd_pkg::CL_NIB_XCH; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_JMP_A_DP: begin
				c = cmbd_pkg::CL_JMP_A_DP; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_JZ: begin
				c = cmbd_pkg::CL_JZ; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_JNZ: begin
				c = cmbd_pkg::CL_JNZ; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_JC: begin
				c = cmbd_pkg::CL_JC; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_JNC: begin
				c = cmbd_pkg::CL_JNC; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_JB: begin
				c = cmbd_pkg::CL_JB; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_JNB: begin
				c = cmbd_pkg::CL_JNB; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_JB_CLR: begin
				c = cmbd_pkg::CL_JB_CLR; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_CMP_A_DIR: begin
				c = cmbd_pkg::CL_CMP_A_DIR; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_CMP_A_IMM: begin
				c = cmbd_pkg::CL_CMP_A_IMM; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			[cmbd_pkg::OP_CMP_REG_LO:cmbd_pkg::OP_CMP_REG_HI]: begin
				c = cmbd_pkg::CL_CMP_REG; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			[cmbd_pkg::OP_DEC_REG_LO:cmbd_pkg::OP_DEC_REG_HI]: begin
				c = cmbd_pkg::CL_DEC_REG; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_DEC_DIR: begin
				c = cmbd_pkg::CL_DEC_DIR; l = cmbd_pkg::LEN3; y = cmbd_pkg::CYC4;
			end
			cmbd_pkg::OP_CLR_BIT: begin
				c = cmbd_pkg::CL_CLR_BIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_SET_BIT: begin
				c = cmbd_pkg::CL_SET_BIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_CPL_BIT: begin
				c = cmbd_pkg::CL_CPL_BIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			cmbd_pkg::OP_ANL_C_BIT: begin
				c = cmbd_pkg::CL_ANL_C_BIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_ANL_C_NBIT: begin
				c = cmbd_pkg::CL_ANL_C_NBIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_ORL_C_BIT: begin
				c = cmbd_pkg::CL_ORL_C_BIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_ORL_C_NBIT: begin
				c = cmbd_pkg::CL_ORL_C_NBIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_MOV_C_BIT: begin
				c = cmbd_pkg::CL_MOV_C_BIT; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC2;
			end
			cmbd_pkg::OP_MOV_BIT_C: begin
				c = cmbd_pkg::CL_MOV_BIT_C; l = cmbd_pkg::LEN2; y = cmbd_pkg::CYC3;
			end
			default: begin
				c = cmbd_pkg::CL_OTHER; l = cmbd_pkg::LEN1; y = cmbd_pkg::CYC1;
			end
		endcase
		return {c, l, y};
	endfunction : decode

	// ==========================================================
	// sequencer state
	cmbd_pkg::cmbd_state_t state_reg;
	cmbd_pkg::cmbd_state_t state_next;
	cmbd_pkg::cmbd_class_t cls_reg;
	logic [7:0]            opcode_reg;
	logic [1:0]            len_reg;
	logic [1:0]            left_reg;
	logic [2:0]            cyc_reg;
	logic [2:0]            cnt_reg;
	logic [7:0]            op1_reg;
	logic [7:0]            op2_reg;
	logic [15:0]           pc_reg;
	logic                  rd_reg;

	// ==========================================================
	// per-cycle decode of the byte stream
	wire logic [10:0]           dec_word   = decode(code_data);
	wire cmbd_pkg::cmbd_class_t dec_cls    = cmbd_pkg::cmbd_class_t'(dec_word[10:5]);
	wire logic                  in_fetch   = (state_reg == cmbd_pkg::ST_FETCH);
	wire logic                  take       = rd_reg & code_valid;
	wire logic                  active     = ~in_fetch | take;
	wire cmbd_pkg::cmbd_class_t cls_now    = in_fetch ? dec_cls : cls_reg;
	wire logic [7:0]            opcode_now = in_fetch ? code_data : opcode_reg;
	wire logic [1:0]            len_now    = in_fetch ? dec_word[4:3] : len_reg;
	wire logic [2:0]            cyc_now    = in_fetch ? dec_word[2:0] : cyc_reg;
	wire logic [1:0]            left_now   = in_fetch ? len_now - 2'h1 :
	                                         left_reg - {1'b0, take};
	wire logic [2:0]            cnt_now    = in_fetch ? 3'h1 :
	                                         (cnt_reg == cmbd_pkg::CYC5 ? cnt_reg : cnt_reg + 3'h1);
	wire logic [1:0]            byte_idx   = len_reg - left_reg;
	wire logic                  cap_op1    = ~in_fetch & take & (byte_idx == 2'h1);
	wire logic                  cap_op2    = ~in_fetch & take & (byte_idx == 2'h2);
	wire logic [7:0]            op1_now    = cap_op1 ? code_data : op1_reg;
	wire logic [7:0]            op2_now    = cap_op2 ? code_data : op2_reg;
	// finish only once every operand byte is in and the cycle budget is spent
	wire logic                  finish     = active & (left_now == 2'h0) & (cnt_now >= cyc_now);
	wire logic [15:0]           pc_seq     = pc_reg + {15'h0000, take};

	// ==========================================================
	// branch resolution
	wire logic [7:0]  rel_byte = (len_now == cmbd_pkg::LEN3) ? op2_now : op1_now;
	wire logic [15:0] rel_tgt  = pc_seq + {{8{rel_byte[7]}}, rel_byte};
	wire logic [15:0] ind_tgt  = data_pointer + {8'h00, acc};
	wire logic        is_ind   = (cls_now == cmbd_pkg::CL_JMP_A_DP);
	logic             taken;

	always_comb begin
		case (cls_now)
			cmbd_pkg::CL_JMP_A_DP:  taken = 1'b1;
			cmbd_pkg::CL_JZ:        taken = acc_is_zero;
			cmbd_pkg::CL_JNZ:       taken = ~acc_is_zero;
			cmbd_pkg::CL_JC:        taken = carry_flag;
			cmbd_pkg::CL_JNC:       taken = ~carry_flag;
			cmbd_pkg::CL_JB:        taken = bit_value;
			cmbd_pkg::CL_JNB:       taken = ~bit_value;
			cmbd_pkg::CL_JB_CLR:    taken = bit_value;
			cmbd_pkg::CL_CMP_A_DIR: taken = compare_unequal;
			cmbd_pkg::CL_CMP_A_IMM: taken = compare_unequal;
			cmbd_pkg::CL_CMP_REG:   taken = compare_unequal;
			cmbd_pkg::CL_DEC_REG:   taken = decrement_nonzero;
			cmbd_pkg::CL_DEC_DIR:   taken = decrement_nonzero;
			default:                taken = 1'b0;
		endcase
	end

	wire logic [15:0] pc_next  = (finish & taken) ? (is_ind ? ind_tgt : rel_tgt) : pc_seq;
	wire logic        is_xmem  = (cls_now == cmbd_pkg::CL_XRD_IND) | (cls_now == cmbd_pkg::CL_XRD_DP) |
	                             (cls_now == cmbd_pkg::CL_XWR_IND) | (cls_now == cmbd_pkg::CL_XWR_DP);
	wire logic        xmem_alt = is_xmem & power_control[cmbd_pkg::XMEM_SEL_BIT];

	// ==========================================================
	// next state
	always_comb begin
		case (state_reg)
			cmbd_pkg::ST_FETCH:   state_next = (take & ~finish) ?
			                       (left_now != 2'h0 ? cmbd_pkg::ST_OPERAND : cmbd_pkg::ST_EXEC) :
			                       cmbd_pkg::ST_FETCH;
			cmbd_pkg::ST_OPERAND: state_next = finish ? cmbd_pkg::ST_FETCH :
			                       (left_now == 2'h0 ? cmbd_pkg::ST_EXEC : cmbd_pkg::ST_OPERAND);
			cmbd_pkg::ST_EXEC:    state_next = finish ? cmbd_pkg::ST_FETCH : cmbd_pkg::ST_EXEC;
			default:              state_next = cmbd_pkg::ST_FETCH;
		endcase
	end

	wire logic rd_next = (state_next == cmbd_pkg::ST_FETCH) | (state_next == cmbd_pkg::ST_OPERAND);

	// ==========================================================
	// registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= cmbd_pkg::ST_FETCH;
			rd_reg    <= 1'b0;
			pc_reg    <= 16'h0000;
		end else begin
			state_reg <= state_next;
			rd_reg    <= rd_next;
			pc_reg    <= pc_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cls_reg    <= cmbd_pkg::CL_OTHER;
			opcode_reg <= 8'h00;
			len_reg    <= cmbd_pkg::LEN1;
			cyc_reg    <= cmbd_pkg::CYC1;
			left_reg   <= 2'h0;
			cnt_reg    <= 3'h0;
			op1_reg    <= 8'h00;
			op2_reg    <= 8'h00;
		end else begin
			if (in_fetch & take) begin
				cls_reg    <= dec_cls;
				opcode_reg <= code_data;
				len_reg    <= len_now;
				cyc_reg    <= cyc_now;
			end
			left_reg <= active ? left_now : left_reg;
			cnt_reg  <= active ? cnt_now : cnt_reg;
			op1_reg  <= op1_now;
			op2_reg  <= op2_now;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			exec_valid     <= 1'b0;
			exec_class     <= cmbd_pkg::CL_OTHER;
			exec_opcode    <= 8'h00;
			exec_op1       <= 8'h00;
			exec_op2       <= 8'h00;
			exec_taken     <= 1'b0;
			exec_bit_clear <= 1'b0;
			exec_xmem_alt  <= 1'b0;
		end else begin
			exec_valid <= finish;
			if (finish) begin
				exec_class     <= cls_now;
				exec_opcode    <= opcode_now;
				exec_op1       <= op1_now;
				exec_op2       <= op2_now;
				exec_taken     <= taken;
				exec_bit_clear <= taken & (cls_now == cmbd_pkg::CL_JB_CLR);
				exec_xmem_alt  <= xmem_alt;
			end
		end
	end

	assign code_rd         = rd_reg;
	assign program_counter = pc_reg;
	assign operand1        = op1_reg;

endmodule : cmbd_decoder

`default_nettype wire

// ==== design/cmbd_pkg.sv ====
// Package for the move, branch and bit-manipulation instruction decoder.
// Assumes one core clock; widths match an 8-bit core with 16-bit code addresses.
package cmbd_pkg;

	// ==========================================================
	// instruction lengths and execution cycle counts
	localparam logic [1:0] LEN1 = 2'h1;
	localparam logic [1:0] LEN2 = 2'h2;
	localparam logic [1:0] LEN3 = 2'h3;
	localparam logic [2:0] CYC1 = 3'h1;
	localparam logic [2:0] CYC2 = 3'h2;
	localparam logic [2:0] CYC3 = 3'h3;
	localparam logic [2:0] CYC4 = 3'h4;
	localparam logic [2:0] CYC5 = 3'h5;

	// ==========================================================
	// power control field steering external moves
	localparam int XMEM_SEL_BIT = 4;

	// ==========================================================
	// opcode encodings
	localparam logic [7:0] OP_MOV_A_REG_LO   = 8'he8;
	localparam logic [7:0] OP_MOV_A_REG_HI   = 8'hef;
	localparam logic [7:0] OP_MOV_A_DIR      = 8'he5;
	localparam logic [7:0] OP_MOV_A_IMM      = 8'h74;
	localparam logic [7:0] OP_MOV_REG_A_LO   = 8'hf8;
	localparam logic [7:0] OP_MOV_REG_A_HI   = 8'hff;
	localparam logic [7:0] OP_MOV_REG_DIR_LO = 8'ha8;
	localparam logic [7:0] OP_MOV_REG_DIR_HI = 8'haf;
	localparam logic [7:0] OP_MOV_DIR_DIR    = 8'h85;
	localparam logic [7:0] OP_LOAD_DP        = 8'h90;
	localparam logic [7:0] OP_CODE_LOAD_DP   = 8'h93;
	localparam logic [7:0] OP_CODE_LOAD_PC   = 8'h83;
	localparam logic [7:0] OP_XRD_IND_LO     = 8'he2;
	localparam logic [7:0] OP_XRD_IND_HI     = 8'he3;
	localparam logic [7:0] OP_XRD_DP         = 8'he0;
	localparam logic [7:0] OP_XWR_IND_LO     = 8'hf2;
	localparam logic [7:0] OP_XWR_IND_HI     = 8'hf3;
	localparam logic [7:0] OP_XWR_DP         = 8'hf0;
	localparam logic [7:0] OP_PUSH           = 8'hc0;
	localparam logic [7:0] OP_POP            = 8'hd0;
	localparam logic [7:0] OP_XCH_REG_LO     = 8'hc8;
	localparam logic [7:0] OP_XCH_REG_HI     = 8'hcf;
	localparam logic [7:0] OP_XCH_IND_LO     = 8'hc6;
	localparam logic [7:0] OP_XCH_IND_HI     = 8'hc7;
	localparam logic [7:0] OP_XCH_DIR        = 8'hc5;
	localparam logic [7:0] OP_NIB_XCH_LO     = 8'hd6;
	localparam logic [7:0] OP_NIB_XCH_HI     = 8'hd7;
	localparam logic [7:0] OP_JMP_A_DP       = 8'h73;
	localparam logic [7:0] OP_JZ             = 8'h60;
	localparam logic [7:0] OP_JNZ            = 8'h70;
	localparam logic [7:0] OP_JC             = 8'h40;
	localparam logic [7:0] OP_JNC            = 8'h50;
	localparam logic [7:0] OP_JB             = 8'h20;
	localparam logic [7:0] OP_JNB            = 8'h30;
	localparam logic [7:0] OP_JB_CLR         = 8'h10;
	localparam logic [7:0] OP_CMP_A_DIR      = 8'hb5;
	localparam logic [7:0] OP_CMP_A_IMM      = 8'hb4;
	localparam logic [7:0] OP_CMP_REG_LO     = 8'hb8;
	localparam logic [7:0] OP_CMP_REG_HI     = 8'hbf;
	localparam logic [7:0] OP_DEC_REG_LO     = 8'hd8;
	localparam logic [7:0] OP_DEC_REG_HI     = 8'hdf;
	localparam logic [7:0] OP_DEC_DIR        = 8'hd5;
	localparam logic [7:0] OP_CLR_BIT        = 8'hc2;
	localparam logic [7:0] OP_SET_BIT        = 8'hd2;
	localparam logic [7:0] OP_CPL_BIT        = 8'hb2;
	localparam logic [7:0] OP_ANL_C_BIT      = 8'h82;
	localparam logic [7:0] OP_ANL_C_NBIT     = 8'hb0;
	localparam logic [7:0] OP_ORL_C_BIT      = 8'h72;
	localparam logic [7:0] OP_ORL_C_NBIT     = 8'ha0;
	localparam logic [7:0] OP_MOV_C_BIT      = 8'ha2;
	localparam logic [7:0] OP_MOV_BIT_C      = 8'h92;

	// ==========================================================
	// decoded operation classes
	typedef enum logic [5:0] {
		CL_OTHER, CL_MOV_A_REG, CL_MOV_A_DIR, CL_MOV_A_IMM, CL_MOV_REG_A,
		CL_MOV_REG_DIR, CL_MOV_DIR_DIR, CL_LOAD_DP, CL_CODE_LOAD_DP, CL_CODE_LOAD_PC,
		CL_XRD_IND, CL_XRD_DP, CL_XWR_IND, CL_XWR_DP, CL_PUSH, CL_POP,
		CL_XCH_REG, CL_XCH_IND, CL_XCH_DIR, CL_NIB_XCH, CL_JMP_A_DP,
		CL_JZ, CL_JNZ, CL_JC, CL_JNC, CL_JB, CL_JNB, CL_JB_CLR,
		CL_CMP_A_DIR, CL_CMP_A_IMM, CL_CMP_REG, CL_DEC_REG, CL_DEC_DIR,
		CL_CLR_BIT, CL_SET_BIT, CL_CPL_BIT, CL_ANL_C_BIT, CL_ANL_C_NBIT,
		CL_ORL_C_BIT, CL_ORL_C_NBIT, CL_MOV_C_BIT, CL_MOV_BIT_C
	} cmbd_class_t;

	// ==========================================================
	// sequencer states, gray along fetch -> operands -> exec
	typedef enum logic [1:0] {
		ST_FETCH   = 2'h0,
		ST_OPERAND = 2'h1,
		ST_EXEC    = 2'h3
	} cmbd_state_t;

endpackage : cmbd_pkg

// ==== sim/cmbd_code_mem.sv ====
// Code memory model answering held code reads, with optional random waits.
// Assumes the bench fills mem while the decoder is held in reset.
`timescale 1ns/100ps
`default_nettype none
module cmbd_code_mem (
	// fetch request
	input  wire logic        mclk,
	input  wire logic        code_rd,
	input  wire logic [15:0] program_counter,
	input  wire logic        wait_en,
	// answer
	output var logic         code_valid,
	output logic [7:0]       code_data
);
	logic [7:0] mem [256];
	logic [7:0] junk_reg = 8'h5a;
	always @(posedge mclk) begin
		code_valid <= wait_en ? 1'($urandom_range(1)) : 1'b1;
		junk_reg   <= junk_reg + 8'h3b;
	end
	// off-beat data moves every cycle
	assign code_data = (code_rd && code_valid) ? mem[program_counter[7:0]] : junk_reg;
endmodule : cmbd_code_mem
`default_nettype wire

// ==== sim/cmbd_decoder_chk.sv ====
// Assertions on the decoder's fetch and execute report ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cmbd_decoder_chk (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  reset,
	// fetch
	input wire logic                  code_rd,
	input wire logic                  code_valid,
	input wire logic [15:0]           program_counter,
	// status
	input wire logic                  carry_flag,
	input wire logic [7:0]            power_control,
	// report
	input wire logic                  exec_valid,
	input wire cmbd_pkg::cmbd_class_t exec_class,
	input wire logic                  exec_taken,
	input wire logic                  exec_bit_clear,
	input wire logic                  exec_xmem_alt
);
	wire logic xsel = power_control[cmbd_pkg::XMEM_SEL_BIT];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// ==========================================================
	// assertions
	reset_exit_a: assert property ($past(reset) |->
		!code_rd && !exec_valid && program_counter == 16'h0 ##1 code_rd) else $error("bad reset exit");
	pc_step_a: assert property (code_rd && code_valid |=>
		program_counter == $past(program_counter) + 16'h1 || exec_valid && exec_taken)
		else $error("counter not stepped");
	pc_hold_a: assert property ($changed(program_counter) |->
		$past(code_rd && code_valid) || exec_valid) else $error("counter moved alone");
	single_cycle_a: assert property (exec_valid && $past(exec_valid) |->
		exec_class inside {cmbd_pkg::CL_OTHER, cmbd_pkg::CL_MOV_A_REG}) else $error("too fast");
	branch_only_a: assert property (exec_valid && exec_taken |->
		exec_class inside {[cmbd_pkg::CL_JMP_A_DP:cmbd_pkg::CL_DEC_DIR]}) else $error("bad taken");
	jump_taken_a: assert property (exec_valid && exec_class == cmbd_pkg::CL_JMP_A_DP |->
		exec_taken) else $error("indirect jump not taken");
	carry_branch_a: assert property (exec_valid && exec_class inside {cmbd_pkg::CL_JC,
		cmbd_pkg::CL_JNC} |-> exec_taken == ($past(carry_flag) ^ (exec_class == cmbd_pkg::CL_JNC)))
		else $error("carry branch wrong");
	bit_clear_a: assert property (exec_valid |-> exec_bit_clear ==
		(exec_class == cmbd_pkg::CL_JB_CLR && exec_taken)) else $error("bit clear wrong");
	xmem_alt_a: assert property (exec_valid |-> exec_xmem_alt == ($past(xsel) &&
		exec_class inside {[cmbd_pkg::CL_XRD_IND:cmbd_pkg::CL_XWR_DP]})) else $error("alt wrong");
	taken_c: cover property (exec_valid && exec_taken);
	alt_c: cover property (exec_valid && exec_xmem_alt);
	b2b_c: cover property (exec_valid ##1 exec_valid);
endmodule : cmbd_decoder_chk
`default_nettype wire

// ==== sim/cmbd_decoder_tb.sv ====
// Bench: runs every decoded class from a code memory model, with and without waits.
// Assumes the package, decoder, memory model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module cmbd_decoder_tb;
	typedef struct packed {
		logic [5:0] cls;
		logic [7:0] op, o1, o2;
		logic [1:0] len;
		logic [2:0] cyc;
		logic       tk, bc, xa;
	} cmbd_exp_t;
	// opcode, length, cycles, span-1 per class in enum order
	localparam logic [19:0] TBL [42] = '{
		20'h00110, 20'he8117, 20'he5220, 20'h74220, 20'hf8127, 20'ha8247, 20'h85340,
		20'h90330, 20'h93130, 20'h83130, 20'he2141, 20'he0140, 20'hf2151, 20'hf0150,
		20'hc0240, 20'hd0230, 20'hc8127, 20'hc6131, 20'hc5230, 20'hd6131, 20'h73120,
		20'h60230, 20'h70230, 20'h40230, 20'h50230, 20'h20340, 20'h30340, 20'h10340,
		20'hb5340, 20'hb4340, 20'hb8347, 20'hd8237, 20'hd5340, 20'hc2230, 20'hd2230,
		20'hb2230, 20'h82220, 20'hb0220, 20'h72220, 20'ha0220, 20'ha2220, 20'h92230};
	logic                  mclk = 1'b0, reset = 1'b1, wait_en = 1'b0, code_rd, code_valid;
	logic                  acc_is_zero = 1'b0, carry_flag = 1'b0, bit_value = 1'b0;
	logic                  compare_unequal = 1'b0, decrement_nonzero = 1'b0;
	logic                  exec_valid, exec_taken, exec_bit_clear, exec_xmem_alt;
	logic [7:0]            acc = 8'h0, power_control = 8'h0, code_data, operand1;
	logic [7:0]            exec_opcode, exec_op1, exec_op2;
	logic [15:0]           data_pointer = 16'h0, program_counter;
	cmbd_pkg::cmbd_class_t exec_class;
	cmbd_exp_t             q[$];
	int                    tq[$];
	logic                  is_op [256];
	int                    failures = 0, comparisons = 0, cyc_n = 0, k;
	cmbd_decoder u_cmbd_decoder (.mclk(mclk), .reset(reset), .code_rd(code_rd),
		.program_counter(program_counter), .code_data(code_data), .code_valid(code_valid),
		.acc(acc), .data_pointer(data_pointer), .acc_is_zero(acc_is_zero),
		.carry_flag(carry_flag), .bit_value(bit_value), .compare_unequal(compare_unequal),
		.decrement_nonzero(decrement_nonzero), .power_control(power_control),
		.operand1(operand1), .exec_valid(exec_valid), .exec_class(exec_class),
		.exec_opcode(exec_opcode), .exec_op1(exec_op1), .exec_op2(exec_op2),
		.exec_taken(exec_taken), .exec_bit_clear(exec_bit_clear), .exec_xmem_alt(exec_xmem_alt));
	cmbd_code_mem u_cmbd_code_mem (.mclk(mclk), .code_rd(code_rd), .wait_en(wait_en),
		.program_counter(program_counter), .code_valid(code_valid), .code_data(code_data));
	initial forever #2 mclk = ~mclk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t op %h seen %h want %h", $time, exec_opcode, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// lay out one instance of every class, forward branch offsets of 0 to 3
	task automatic build();
		cmbd_exp_t   e;
		logic [7:0]  a;
		logic [7:0]  d;
		a = 8'h0;
		for (int j = 0; j < 256; j++) begin
			u_cmbd_code_mem.mem[j] = 8'h00;
			is_op[j] = 1'b0;
		end
		for (int i = 0; i < 42; i++) begin
			e = {6'(i), TBL[i][19:12] + 8'($urandom_range(int'(TBL[i][3:0]))), 8'($urandom),
				(i > 20 && i < 33) ? 8'h00 : 8'($urandom), TBL[i][9:8], TBL[i][6:4], 3'h0};
			case (i)
				20: e.tk = 1'b1;
				21, 22: e.tk = acc_is_zero ^ (i == 22);
				23, 24: e.tk = carry_flag ^ (i == 24);
				25, 27: e.tk = bit_value;
				26: e.tk = !bit_value;
				28, 29, 30: e.tk = compare_unequal;
				31, 32: e.tk = decrement_nonzero;
				default: e.tk = 1'b0;
			endcase
			e.bc = (i == 27) && bit_value;
			// forward offset: a taken branch skips d filler bytes
			d = 8'($urandom_range(3));
			if (i > 20 && i < 33 && e.len == 2'h2) e.o1 = d;
			if (i > 20 && i < 33 && e.len == 2'h3) e.o2 = d;
			e.xa = (i > 9 && i < 14) && power_control[cmbd_pkg::XMEM_SEL_BIT];
			if (i == 20) data_pointer = 16'(a) + 16'h1 - 16'(acc);
			is_op[a] = 1'b1;
			u_cmbd_code_mem.mem[a] = e.op;
			u_cmbd_code_mem.mem[a + 8'h1] = (e.len > 2'h1) ? e.o1 : 8'h00;
			u_cmbd_code_mem.mem[a + 8'h2] = (e.len > 2'h2) ? e.o2 : 8'h00;
			a = a + 8'(e.len) + ((e.tk && i > 20) ? d : 8'h00);
			q.push_back(e);
		end
	endtask : build
	// ==========================================================
	// monitor: opcode beat times and execute reports
	always @(negedge mclk) begin
		cmbd_exp_t e;
		cyc_n++;
		if (cyc_n > 12000) begin
			failures++;
			tally_and_finish();
		end
		if (reset) tq.delete();
		else begin
			if (code_rd && code_valid && is_op[program_counter[7:0]]) tq.push_back(cyc_n);
			if (exec_valid === 1'b1 && q.size() > 0) begin
				e = q.pop_front();
				check(exec_class, e.cls);
				check(exec_opcode, e.op);
				if (e.len > 2'h1) check(exec_op1, e.o1);
				if (e.len > 2'h1) check(operand1, e.o1);
				if (e.len > 2'h2) check(exec_op2, e.o2);
				check({exec_taken, exec_bit_clear, exec_xmem_alt}, {e.tk, e.bc, e.xa});
				if (!wait_en && tq.size() > 0) check(16'(cyc_n - tq[0]), e.cyc);
				if (tq.size() > 0) void'(tq.pop_front());
			end
		end
	end
	initial begin
		void'($urandom(32'h5547));
		for (int p = 0; p < 6; p++) begin
			reset = 1'b1;
			wait_en = p[0];
			{acc_is_zero, carry_flag, bit_value, compare_unequal, decrement_nonzero} = 5'($urandom);
			acc = 8'($urandom);
			power_control = 8'($urandom);
			build();
			repeat (4) @(negedge mclk);
			reset = 1'b0;
			for (k = 0; k < 1500 && q.size() > 0; k++) @(negedge mclk);
			if (q.size() > 0) failures++;
			q.delete();
		end
		tally_and_finish();
	end
endmodule : cmbd_decoder_tb
bind cmbd_decoder cmbd_decoder_chk u_cmbd_decoder_chk (.mclk(mclk), .reset(reset),
	.code_rd(code_rd), .code_valid(code_valid), .program_counter(program_counter),
	.carry_flag(carry_flag), .power_control(power_control), .exec_valid(exec_valid),
	.exec_class(exec_class), .exec_taken(exec_taken), .exec_bit_clear(exec_bit_clear),
	.exec_xmem_alt(exec_xmem_alt));
`default_nettype wire
